/* File: sbap_pkg.sv */
package sbap_pkg;
  // acknowledge codes
  localparam logic [7:0] SBAP_ACK_UART = 8'h86;
  localparam logic [7:0] SBAP_ACK_IOIF = 8'h30;
  localparam logic [7:0] SBAP_CMD_RAM = 8'h10;
  localparam logic [7:0] SBAP_CMD_SUM = 8'h20;
  localparam logic [7:0] SBAP_CMD_INFO = 8'h30;
  localparam logic [7:0] SBAP_CMD_ERASE = 8'h40;
  localparam logic [7:0] SBAP_ERASE_EN = 8'h54;
  localparam logic [7:0] SBAP_ERASE_OK = 8'h4f;
  localparam logic [7:0] SBAP_ERASE_BAD = 8'h4c;
  localparam logic [7:0] SBAP_PW_ERASED = 8'hff;
  // acknowledge field positions
  localparam int SBAP_BIT_RXERR = 3;
  localparam int SBAP_BIT_INVAL = 0;
  // transfer layout of the ram transfer command
  localparam logic [4:0] SBAP_PW_LEN = 5'h0c;
  localparam logic [4:0] SBAP_RAM_HDR = 5'h04;
  // flash sum covers 512 kbytes
  localparam int SBAP_FLASH_AW = 19;
  localparam logic [SBAP_FLASH_AW-1:0] SBAP_FLASH_LAST = 19'h7ffff;
  localparam logic [SBAP_FLASH_AW-1:0] SBAP_PW_BASE = 19'h7fff4;
  // mode detection edge count
  localparam logic [2:0] SBAP_EDGES = 3'h4;
  localparam int SBAP_TW = 20;
  localparam int SBAP_FIFO_DEPTH = 8;
  localparam int SBAP_FIFO_AW = 3;

  typedef enum logic [3:0] {
    SBAP_S_DETECT = 4'b0000,
    SBAP_S_MODE_ACK = 4'b0001,
    SBAP_S_CMD = 4'b0011,
    SBAP_S_RAM_HDR = 4'b0010,
    SBAP_S_RAM_PW = 4'b0110,
    SBAP_S_RAM_CK = 4'b0111,
    SBAP_S_SUM = 4'b0101,
    SBAP_S_SUM_TX = 4'b0100,
    SBAP_S_ERASE_EN = 4'b1100,
    SBAP_S_ERASE_RUN = 4'b1101,
    SBAP_S_HALT = 4'b1111,
    SBAP_S_PW_READ = 4'b1110
  } sbap_state_t;

  // acknowledge byte formed from the governing command nibble and flags
  function automatic logic [7:0] sbap_ack(input logic [3:0] hi, input logic rxerr,
                                          input logic inval);
    logic [7:0] a;
    a = {hi, 4'h0};
    a[SBAP_BIT_RXERR] = rxerr;
    a[SBAP_BIT_INVAL] = inval & ~rxerr;
    return a;
  endfunction
endpackage

/* File: sbap_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
// byte stream between the engine and the reply fifo
interface sbap_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: sbap_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sbap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  sbap_stream_if.snk wr,
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic do_wr, do_rd;
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign do_wr = wr.valid & wr.ready;
  assign do_rd = rd_valid & rd_ready;

  // storage written only on accepted words
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  // pointers and fill level; pop may free the slot that a push takes next cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) wp_q <= wp_q + 1'b1;
      if (do_rd) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // read data registered: head word sits in a flop, refreshed after each pop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (!rd_valid || do_rd) begin
      rd_valid <= (cnt_q != '0) && !(do_rd && cnt_q == (AW+1)'(1)) ? 1'b1 : 1'b0;
      rd_data <= do_rd ? mem_q[rp_q + 1'b1] : mem_q[rp_q];
    end
  end
endmodule // sbap_fifo
`default_nettype wire

/* File: sbap_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module sbap_engine
  import sbap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_pin,
  input wire logic baud_ok,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_error,
  output logic rx_enable,
  output logic link_is_uart,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [SBAP_FLASH_AW-1:0] flash_addr,
  input wire logic [7:0] flash_data,
  output logic info_start,
  input wire logic info_valid,
  input wire logic [7:0] info_data,
  input wire logic info_last,
  output logic erase_start,
  input wire logic erase_done,
  input wire logic erase_fail,
  output logic ram_pass,
  output logic halted
);
  logic rst_meta_q, rst_sync_q, rrst_n;
  // release reset through two flops so every flop leaves reset on one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rrst_n = rst_sync_q;

  // replies queue here; the sequencer moves on while the controller drains them
  sbap_stream_if txs ();
  sbap_fifo #(.WIDTH(8), .DEPTH(SBAP_FIFO_DEPTH), .AW(SBAP_FIFO_AW)) u_fifo (
    .clk(clk),
    .rst_n(rrst_n),
    .wr(txs),
    .rd_ready(tx_ready),
    .rd_valid(tx_valid),
    .rd_data(tx_data)
  );

  sbap_state_t st_q;
  logic [SBAP_TW-1:0] tmr_q;
  logic [SBAP_TW-1:0] t_first_q, t_ab_q;
  logic [SBAP_TW-1:0] interval_first_to_third_edge_q, interval_first_to_fourth_edge_q;
  logic [SBAP_TW-1:0] interval_third_to_fourth_edge;
  logic [2:0] edges_q;
  logic rx_prev_q, uart_q;
  logic [3:0] cmd_hi_q, op_hi_q;
  logic [7:0] csum_q;
  logic [4:0] idx_q;
  logic pw_bad_q, pw_uniform_q;
  logic [7:0] pw_first_q;
  logic [15:0] sum_q;
  logic [1:0] sum_phase_q;
  logic [SBAP_FLASH_AW-1:0] fa_q;
  logic push;
  logic [7:0] push_data;
  logic rx_err_eff;

  assign rx_err_eff = rx_error & uart_q;
  // both long intervals start at the first edge, so their difference is the last one
  assign interval_third_to_fourth_edge = interval_first_to_fourth_edge_q -
                                         interval_first_to_third_edge_q;
  assign txs.valid = push;
  assign txs.data = push_data;
  assign rx_enable = (st_q != SBAP_S_DETECT) && (st_q != SBAP_S_HALT);
  assign link_is_uart = uart_q;
  assign halted = (st_q == SBAP_S_HALT);
  assign flash_addr = fa_q;

  // free-running timestamp counter
  always_ff @(posedge clk or negedge rrst_n) begin
    if (!rrst_n) tmr_q <= '0;
    else tmr_q <= tmr_q + 1'b1;
  end

  // edge capture of the first byte while reception is off
  always_ff @(posedge clk or negedge rrst_n) begin
    if (!rrst_n) begin
      rx_prev_q <= 1'b1;
      edges_q <= '0;
      t_first_q <= '0;
      t_ab_q <= '0;
      interval_first_to_third_edge_q <= '0;
      interval_first_to_fourth_edge_q <= '0;
    end else begin
      rx_prev_q <= rx_pin;
      if (st_q == SBAP_S_DETECT && rx_pin != rx_prev_q && edges_q != SBAP_EDGES) begin
        edges_q <= edges_q + 1'b1;
        unique case (edges_q)
          3'h0: t_first_q <= tmr_q;
          3'h1: t_ab_q <= tmr_q - t_first_q;
          3'h2: interval_first_to_third_edge_q <= tmr_q - t_first_q;
          default: interval_first_to_fourth_edge_q <= tmr_q - t_first_q;
        endcase
      end
    end
  end

  // codes that start an operation; undefined codes must not steer the reply nibble
  function automatic logic is_known_cmd(input logic [7:0] c);
    return (c == SBAP_CMD_RAM) || (c == SBAP_CMD_SUM) || (c == SBAP_CMD_INFO) ||
           (c == SBAP_CMD_ERASE);
  endfunction

  // pushes into the reply fifo; the engine waits when the fifo is full, except in SBAP_S_SUM, which pushes info bytes regardless
  always_comb begin
    push = 1'b0;
    push_data = 8'h00;
    unique case (st_q)
      SBAP_S_MODE_ACK: begin
        push = uart_q ? baud_ok : 1'b1;
        push_data = uart_q ? SBAP_ACK_UART : SBAP_ACK_IOIF;
      end
      SBAP_S_CMD: begin
        push = rx_valid;
        if (rx_err_eff) push_data = sbap_ack(cmd_hi_q, 1'b1, 1'b0);
        else if (is_known_cmd(rx_data))
          push_data = rx_data;
        else push_data = sbap_ack(cmd_hi_q, 1'b0, 1'b1);
      end
      SBAP_S_RAM_CK: begin
        push = rx_valid;
        push_data = sbap_ack(op_hi_q, rx_err_eff,
                             (pw_uniform_q && pw_first_q != SBAP_PW_ERASED) || pw_bad_q ||
                             (csum_q + rx_data) != 8'h00);
      end
      SBAP_S_SUM_TX: begin
        push = 1'b1;
        unique case (sum_phase_q)
          2'h0: push_data = sum_q[15:8];
          2'h1: push_data = sum_q[7:0];
          default: push_data = 8'h00 - (sum_q[15:8] + sum_q[7:0]);
        endcase
      end
      SBAP_S_SUM: begin
        push = info_valid; // product data forwarded; the source cannot be stalled
        push_data = info_data;
      end
      SBAP_S_ERASE_EN: begin
        push = rx_valid;
        if (rx_err_eff) push_data = sbap_ack(cmd_hi_q, 1'b1, 1'b0);
        else if (rx_data == SBAP_ERASE_EN) push_data = SBAP_ERASE_EN;
        else push_data = sbap_ack(cmd_hi_q, 1'b0, 1'b1);
      end
      SBAP_S_ERASE_RUN: begin
        push = erase_done;
        push_data = erase_fail ? SBAP_ERASE_BAD : SBAP_ERASE_OK;
      end
      default: begin
        push = 1'b0;
        push_data = 8'h00;
      end
    endcase
  end

  // product info checksum, appended after the last info byte
  logic [7:0] info_sum_q;
  logic info_tail_q, info_run_q;
  always_ff @(posedge clk or negedge rrst_n) begin
    if (!rrst_n) begin
      info_sum_q <= '0;
      info_tail_q <= 1'b0;
    end else if (st_q == SBAP_S_SUM && info_run_q && info_valid && txs.ready) begin
      info_sum_q <= info_sum_q + info_data;
      info_tail_q <= info_last;
    end else if (st_q == SBAP_S_CMD) begin
      info_sum_q <= '0;
      info_tail_q <= 1'b0;
    end
  end

  // main sequencer
  always_ff @(posedge clk or negedge rrst_n) begin
    if (!rrst_n) begin
      st_q <= SBAP_S_DETECT;
      uart_q <= 1'b0;
      cmd_hi_q <= '0;
      op_hi_q <= '0;
      csum_q <= '0;
      idx_q <= '0;
      pw_bad_q <= 1'b0;
      pw_uniform_q <= 1'b1;
      pw_first_q <= '0;
      sum_q <= '0;
      sum_phase_q <= '0;
      fa_q <= '0;
      info_start <= 1'b0;
      info_run_q <= 1'b0;
      erase_start <= 1'b0;
      ram_pass <= 1'b0;
    end else begin
      info_start <= 1'b0;
      erase_start <= 1'b0;
      unique case (st_q)
        SBAP_S_DETECT: begin
          if (edges_q == SBAP_EDGES) begin
            uart_q <= (t_ab_q <= interval_third_to_fourth_edge);
            st_q <= SBAP_S_MODE_ACK;
          end
        end
        SBAP_S_MODE_ACK: begin
          if (uart_q && !baud_ok) st_q <= SBAP_S_HALT;
          else if (txs.ready) begin
            cmd_hi_q <= uart_q ? SBAP_ACK_UART[7:4] : SBAP_ACK_IOIF[7:4];
            st_q <= SBAP_S_CMD;
          end
        end
        SBAP_S_CMD: begin
          // an undefined code is answered but leaves the governing nibble alone
          if (rx_valid && txs.ready && !rx_err_eff && is_known_cmd(rx_data)) begin
            cmd_hi_q <= rx_data[7:4];
            op_hi_q <= rx_data[7:4];
            csum_q <= '0;
            idx_q <= '0;
            unique case (rx_data)
              SBAP_CMD_RAM: begin
                // pass flag keeps the last verdict until this transfer ends
                pw_bad_q <= 1'b0;
                pw_uniform_q <= 1'b1;
                fa_q <= SBAP_PW_BASE;
                st_q <= SBAP_S_RAM_HDR;
              end
              SBAP_CMD_SUM: begin
                fa_q <= '0;
                sum_q <= '0;
                st_q <= SBAP_S_PW_READ;
              end
              SBAP_CMD_INFO: begin
                info_start <= 1'b1;
                info_run_q <= 1'b1;
                st_q <= SBAP_S_SUM;
              end
              SBAP_CMD_ERASE: st_q <= SBAP_S_ERASE_EN;
              default: st_q <= SBAP_S_CMD;
            endcase
          end
        end
        SBAP_S_RAM_HDR: begin
          // one idle cycle lets the flash address settle before the first password byte
          st_q <= SBAP_S_RAM_PW;
        end
        SBAP_S_RAM_PW: begin
          // flash address leads the byte by one cycle; flash_data is the stored byte
          if (rx_valid) begin
            csum_q <= csum_q + rx_data;
            if (rx_data != flash_data) pw_bad_q <= 1'b1;
            if (idx_q == 5'h00) pw_first_q <= flash_data;
            else if (flash_data != pw_first_q) pw_uniform_q <= 1'b0;
            fa_q <= fa_q + 1'b1;
            idx_q <= idx_q + 1'b1;
            if (idx_q == SBAP_PW_LEN - 5'h01) st_q <= SBAP_S_RAM_CK;
          end
        end
        SBAP_S_RAM_CK: begin
          // the checksum byte closes the transfer; the flag follows the reply bits
          if (rx_valid && txs.ready) begin
            ram_pass <= !push_data[SBAP_BIT_INVAL] && !push_data[SBAP_BIT_RXERR];
            st_q <= SBAP_S_CMD;
          end
        end
        SBAP_S_PW_READ: begin
          // one byte per cycle across the whole array
          sum_q <= sum_q + {8'h00, flash_data};
          if (fa_q == SBAP_FLASH_LAST) begin
            sum_phase_q <= '0;
            st_q <= SBAP_S_SUM_TX;
          end else fa_q <= fa_q + 1'b1;
        end
        SBAP_S_SUM_TX: begin
          if (txs.ready) begin
            sum_phase_q <= sum_phase_q + 1'b1;
            if (sum_phase_q == 2'h2) st_q <= SBAP_S_CMD;
          end
        end
        SBAP_S_SUM: begin
          // the checksum leaves through the sum tail: zero high byte, info sum low
          if (info_tail_q) begin
            info_run_q <= 1'b0;
            sum_q <= {8'h00, info_sum_q};
            sum_phase_q <= 2'h2;
            st_q <= SBAP_S_SUM_TX;
          end
        end
        SBAP_S_ERASE_EN: begin
          if (rx_valid && txs.ready) begin
            if (!rx_err_eff && rx_data == SBAP_ERASE_EN) begin
              erase_start <= 1'b1;
              st_q <= SBAP_S_ERASE_RUN;
            end else st_q <= SBAP_S_CMD;
          end
        end
        SBAP_S_ERASE_RUN: begin
          // a full fifo at completion would lose the result; eight slots make that unlikely
          if (erase_done && txs.ready) st_q <= SBAP_S_CMD;
        end
        // only a reset leaves here; the link rate could not be set up
        SBAP_S_HALT: st_q <= SBAP_S_HALT;
        default: st_q <= SBAP_S_DETECT;
      endcase
    end
  end
endmodule // sbap_engine
`default_nettype wire

/* File: sbap_engine_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sbap_engine_properties
  import sbap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_pin,
  input wire logic rx_enable,
  input wire logic link_is_uart,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic erase_start,
  input wire logic erase_done,
  input wire logic erase_fail,
  input wire logic ram_pass,
  input wire logic halted
);
  logic pin_q;
  logic [2:0] edge_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // counts first-byte edges; saturates so later pin activity is ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
      edge_q <= 3'h0;
    end else begin
      pin_q <= rx_pin;
      if (rx_pin != pin_q && edge_q != SBAP_EDGES) edge_q <= edge_q + 3'h1;
    end
  end
  sequence s_first_byte;
    edge_q == 3'h3 ##1 edge_q == SBAP_EDGES;
  endsequence
  sequence s_erase(logic f);
    erase_start ##[1:40] (erase_done && erase_fail == f);
  endsequence
  chk_mode_ack: assert property (
    s_first_byte |-> ##[1:40] (halted ||
      (tx_valid && tx_data == (link_is_uart ? SBAP_ACK_UART : SBAP_ACK_IOIF))))
    else $error("no mode ack after first byte");
  chk_detect_quiet: assert property (
    edge_q != SBAP_EDGES |-> !rx_enable && !tx_valid)
    else $error("receiver or reply active during detection");
  chk_halt_silent: assert property (
    halted |-> !tx_valid && !rx_enable)
    else $error("halted engine still talks");
  chk_halt_sticky: assert property (
    halted |=> halted)
    else $error("halt left without reset");
  chk_erase_good: assert property (
    s_erase(1'b0) |-> ##[1:8] tx_valid && tx_data == SBAP_ERASE_OK)
    else $error("no erase success code");
  chk_erase_bad: assert property (
    s_erase(1'b1) |-> ##[1:8] tx_valid && tx_data == SBAP_ERASE_BAD)
    else $error("no erase failure code");
  chk_erase_pulse: assert property (
    erase_start |=> !erase_start)
    else $error("erase start longer than a pulse");
  chk_ram_good: assert property (
    $rose(ram_pass) |-> ##[0:8] tx_valid && tx_data == SBAP_CMD_RAM)
    else $error("pass flag without success ack");
  chk_ram_fail: assert property (
    $fell(ram_pass) |-> ##[0:8] tx_valid && tx_data inside {8'h11, 8'h18})
    else $error("pass flag cleared without error ack");
endmodule // sbap_engine_properties
`default_nettype wire

/* File: sbap_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// programming controller plus board flash and eraser
module sbap_ctl_model
  import sbap_pkg::*;
(
  input wire logic clk,
  output logic rx_pin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_error,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic [SBAP_FLASH_AW-1:0] flash_addr,
  output logic [7:0] flash_data,
  input wire logic erase_start,
  output logic erase_done,
  output logic erase_fail
);
  logic [7:0] rxq[$];
  logic [1:0] stall_q = 2'h0;
  logic pw_flat = 1'b0;
  logic fail_next = 1'b0;
  initial begin
    {rx_pin, tx_ready} = 2'h3;
    {rx_valid, rx_error, erase_done, erase_fail} = 4'h0;
    rx_data = 8'h00;
  end
  // flattened flash makes the password area one non-erased value
  assign flash_data = pw_flat ? 8'h33 : flash_addr[7:0] ^ 8'h5a;
  // stall one cycle in four so replies must wait
  always @(negedge clk) begin
    stall_q <= stall_q + 2'h1;
    tx_ready <= stall_q != 2'h3;
  end
  always @(posedge clk) if (tx_valid && tx_ready) rxq.push_back(tx_data);
  always @(posedge erase_start) begin
    repeat (10) @(negedge clk);
    erase_fail <= fail_next;
    erase_done <= 1'b1;
    @(negedge clk);
    erase_done <= 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic err);
    @(negedge clk);
    rx_data <= b;
    rx_error <= err;
    rx_valid <= 1'b1;
    @(negedge clk);
    rx_valid <= 1'b0;
    rx_error <= 1'b0;
    rx_data <= ~b; // released bus shows no stale byte
    repeat (3) @(negedge clk);
  endtask
  // first byte as four pin edges; ab above cd asks for i/o mode
  task automatic edges(input int ab, input int bc, input int cd);
    @(negedge clk) rx_pin <= 1'b0;
    repeat (ab) @(negedge clk);
    rx_pin <= 1'b1;
    repeat (bc) @(negedge clk);
    rx_pin <= 1'b0;
    repeat (cd) @(negedge clk);
    rx_pin <= 1'b1;
  endtask
endmodule // sbap_ctl_model
`default_nettype wire

/* File: sbap_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sbap_engine_bench
  import sbap_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic baud_ok = 1'b0;
  logic rx_pin, rx_valid, rx_error, tx_valid, tx_ready, rx_enable, link_is_uart;
  logic erase_start, erase_done, erase_fail, ram_pass, halted, info_start;
  logic info_valid = 1'b0;
  logic info_last = 1'b0;
  logic [7:0] info_data = 8'h00;
  int info_starts = 0;
  logic [7:0] rx_data, tx_data, flash_data;
  logic [SBAP_FLASH_AW-1:0] flash_addr;
  int errors = 0;
  int n_compared = 0;
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (info_start) info_starts++;
  sbap_engine sbap_engine_i (.clk, .rst_n, .rx_pin, .baud_ok, .rx_valid, .rx_data,
    .rx_error, .rx_enable, .link_is_uart, .tx_valid, .tx_data, .tx_ready,
    .flash_addr, .flash_data, .info_start, .info_valid, .info_data,
    .info_last, .erase_start, .erase_done, .erase_fail, .ram_pass, .halted);
  sbap_ctl_model sbap_ctl_model_i (.clk, .rx_pin, .rx_valid, .rx_data, .rx_error,
    .tx_valid, .tx_data, .tx_ready, .flash_addr, .flash_data, .erase_start,
    .erase_done, .erase_fail);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bounded wait, as a controller gives up on a silent target
  task automatic ack(input logic [7:0] e);
    int n;
    n = 0;
    while (sbap_ctl_model_i.rxq.size() == 0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("reply", e, n < 3000 ? sbap_ctl_model_i.rxq.pop_front() : 8'hxx);
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    sbap_ctl_model_i.rxq.delete();
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask
  // ram transfer: twelve password bytes then negated byte sum
  task automatic ram(input logic [7:0] bad, input logic [7:0] off, input logic err,
                     input logic [7:0] e);
    logic [7:0] s;
    logic [7:0] b;
    s = 8'h00;
    sbap_ctl_model_i.send(SBAP_CMD_RAM, 1'b0);
    ack(SBAP_CMD_RAM);
    repeat (40) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      b = sbap_ctl_model_i.pw_flat ? 8'h33 : (8'hf4 + 8'(i)) ^ 8'h5a;
      if (i == 5) b = b ^ bad;
      s = s + b;
      sbap_ctl_model_i.send(b, 1'b0);
    end
    sbap_ctl_model_i.send(8'h00 - s + off, err);
    ack(e);
    if (!err) chk("ram_pass", {7'h0, e == 8'h10}, {7'h0, ram_pass});
  endtask
  task automatic t_halt;
    do_reset();
    baud_ok = 1'b0;
    sbap_ctl_model_i.edges(16, 16, 32);
    repeat (300) @(negedge clk);
    chk("halted", 8'h01, {7'h0, halted});
    chk("replies", 8'h00, 8'(sbap_ctl_model_i.rxq.size()));
  endtask
  // i/o mode ignores receive errors
  task automatic t_io;
    do_reset();
    sbap_ctl_model_i.edges(40, 20, 10);
    ack(SBAP_ACK_IOIF);
    chk("link", 8'h00, {7'h0, link_is_uart});
    sbap_ctl_model_i.send(SBAP_CMD_ERASE, 1'b1);
    ack(SBAP_CMD_ERASE);
    sbap_ctl_model_i.send(SBAP_ERASE_EN, 1'b0);
    ack(SBAP_ERASE_EN);
    ack(SBAP_ERASE_OK);
    sbap_ctl_model_i.send(SBAP_CMD_SUM, 1'b0);
    ack(SBAP_CMD_SUM);
  endtask
  // equal intervals sit on the uart side of the boundary
  task automatic t_uart;
    do_reset();
    baud_ok = 1'b1;
    sbap_ctl_model_i.fail_next = 1'b1;
    sbap_ctl_model_i.edges(20, 20, 20);
    ack(SBAP_ACK_UART);
    chk("link", 8'h01, {7'h0, link_is_uart});
    sbap_ctl_model_i.send(SBAP_CMD_ERASE, 1'b0);
    ack(SBAP_CMD_ERASE);
    sbap_ctl_model_i.send(SBAP_ERASE_EN, 1'b0);
    ack(SBAP_ERASE_EN);
    ack(SBAP_ERASE_BAD);
    sbap_ctl_model_i.send(8'h77, 1'b0);
    ack(8'h41);
    sbap_ctl_model_i.send(SBAP_CMD_SUM, 1'b1);
    ack(8'h48);
    ram(8'h00, 8'h00, 1'b0, 8'h10);
    sbap_ctl_model_i.send(8'h99, 1'b0);
    ack(8'h11);
    ram(8'h04, 8'h00, 1'b0, 8'h11);
    ram(8'h00, 8'h01, 1'b0, 8'h11);
    ram(8'h00, 8'h00, 1'b1, 8'h18);
    sbap_ctl_model_i.pw_flat = 1'b1;
    ram(8'h00, 8'h00, 1'b0, 8'h11);
    sbap_ctl_model_i.send(SBAP_CMD_INFO, 1'b0);
    ack(SBAP_CMD_INFO);
    chk("info_start", 8'h01, 8'(info_starts));
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      info_valid = 1'b1;
      info_data = 8'h51 + 8'(i);
      info_last = (i == 2);
    end
    @(negedge clk);
    info_valid = 1'b0;
    info_last = 1'b0;
    ack(8'h51);
    ack(8'h52);
    ack(8'h53);
    ack(8'h00 - (8'h51 + 8'h52 + 8'h53));
    sbap_ctl_model_i.send(8'h55, 1'b0);
    ack(8'h31);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // run needs about 1.2k cycles; this cuts a hang at 25k
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
  initial begin
    t_halt();
    t_io();
    t_uart();
    wrap_up();
  end
endmodule // sbap_engine_bench
bind sbap_engine sbap_engine_properties sbap_engine_properties_i (.clk, .rst_n, .rx_pin,
  .rx_enable, .link_is_uart, .tx_valid, .tx_data, .erase_start, .erase_done,
  .erase_fail, .ram_pass, .halted);
`default_nettype wire
